// >>> core/fcb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fcb_top (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Configuration.
  input  wire logic        arch_extended,
  input  wire logic        fpu_enable,
  input  wire logic        precise_model,
  input  wire logic        invalid_enable,
  input  wire logic        invalid_flag_clear,
  // Issued instruction and operands.
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] instr_pc,
  input  wire logic [63:0] operand_a,
  input  wire logic [63:0] operand_b,
  // Branch outcome.
  output logic             branch_redirect,
  output logic [31:0]      branch_target,
  output logic             nullify_delay_slot,
  // Exceptions and status.
  output logic             cop_unusable_exc,
  output logic             reserved_instr_exc,
  output logic             invalid_trap,
  output logic             invalid_trap_late,
  output logic             invalid_flag,
  output logic [7:0]       fp_condition_bits
);
  import fcb_pkg::*;

  // ==========================================================================
  // Decode.
  // ==========================================================================
  wire        is_fp       = instr_valid && (instr_word[OPC_MSB:OPC_LSB] == FP_MAJOR_OPCODE);
  wire [4:0]  sub_field   = instr_word[SUB_MSB:SUB_LSB];
  wire        is_branch   = is_fp && (sub_field == BC_SUB_OPCODE);
  wire        is_cmp      = is_fp && !is_branch &&
                            (instr_word[CLS_MSB:CLS_LSB] == CMP_CLASS);
  wire [2:0]  br_select   = instr_word[BCC_MSB:BCC_LSB];
  wire        nullify_flag   = instr_word[ND_BIT];
  wire        sense_polarity = instr_word[TF_BIT];
  wire [2:0]  cmp_select  = instr_word[CCC_MSB:CCC_LSB];
  wire [3:0]  pred_code   = instr_word[PRED_MSB:PRED_LSB];
  wire        fmt_ok      = (sub_field == FMT_SINGLE) || (sub_field == FMT_DOUBLE);
  wire        fmt_double  = (sub_field == FMT_DOUBLE);

  wire        br_bad      = !arch_extended && (br_select != CC_ZERO);
  wire        cmp_bad     = !fmt_ok || (instr_word[ZRO_MSB:ZRO_LSB] != ZERO_FIELD) ||
                            (!arch_extended && (cmp_select != CC_ZERO));
  wire        unusable    = (is_branch || is_cmp) && !fpu_enable;
  wire        reserved    = fpu_enable &&
                            ((is_branch && br_bad) || (is_cmp && cmp_bad));
  wire        br_ok       = fpu_enable && is_branch && !br_bad;
  wire        cmp_ok      = fpu_enable && is_cmp && !cmp_bad;

  // ==========================================================================
  // Branch.
  // ==========================================================================
  logic        legacy_cc_reg;
  logic [7:0]  fcc_reg;
  wire  [31:0] br_disp    = {{SEXT_W{instr_word[OFF_MSB]}}, instr_word[OFF_MSB:OFF_LSB],
                             {OFF_SHIFT{1'b0}}};
  wire  [31:0] br_target  = instr_pc + SLOT_BYTES + br_disp;
  // Legacy levels look at the code as it stood before the preceding instruction.
  wire         cond_bit   = arch_extended ? fcc_reg[br_select] :
                            legacy_cc_reg;
  wire         br_taken   = (cond_bit == sense_polarity);

  // ==========================================================================
  // Compare.
  // ==========================================================================
  logic rel_gt;
  logic rel_lt;
  logic rel_eq;
  logic rel_un;

  fcb_compare fcb_compare_inst (
    .operand_a (operand_a),
    .operand_b (operand_b),
    .is_double (fmt_double),
    .rel_gt    (rel_gt),
    .rel_lt    (rel_lt),
    .rel_eq    (rel_eq),
    .rel_un    (rel_un)
  );

  wire cmp_result  = (pred_code[PRED_UN] && rel_un) || (pred_code[PRED_EQ] && rel_eq) ||
                     (pred_code[PRED_LT] && rel_lt);
  wire inv_cond    = cmp_ok && pred_code[PRED_SIG] && rel_un;
  wire trap_now    = precise_model && inv_cond && invalid_enable;
  wire cc_write    = cmp_ok && !trap_now;
  wire flag_set    = precise_model && inv_cond;
  wire late_event  = !precise_model && inv_cond && invalid_enable;

  logic [7:0] fcc_next;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CC; gi++) begin : g_cc
      assign fcc_next[gi] = (cc_write && (cmp_select == 3'(gi))) ?
                            cmp_result : fcc_reg[gi];
    end
  endgenerate

  // Event set wins over the software clear.
  wire flag_next = flag_set || (invalid_flag && !invalid_flag_clear);

  // ==========================================================================
  // Deferred trap sequencer.
  // ==========================================================================
  fcb_trap_state_t trap_state_reg;
  fcb_trap_state_t trap_state_next;
  logic [2:0]      late_cnt_reg;
  logic [2:0]      late_cnt_next;
  logic            late_fire;

  always_comb begin
    trap_state_next = trap_state_reg;
    late_cnt_next   = late_cnt_reg;
    late_fire       = 1'b0;
    case (trap_state_reg)
      TRAP_IDLE: begin
        if (late_event) begin
          trap_state_next = TRAP_WAIT;
          late_cnt_next   = LATE_TRAP_CYCLES;
        end
      end
      TRAP_WAIT: begin
        if (late_cnt_reg == 3'h0) begin
          late_fire       = 1'b1;
          trap_state_next = TRAP_IDLE;
        end else begin
          late_cnt_next = late_cnt_reg - 3'h1;
        end
      end
      default: trap_state_next = TRAP_IDLE;
    endcase
  end

  // ==========================================================================
  // State and registered outputs.
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fcc_reg        <= FCC_RESET;
      legacy_cc_reg  <= 1'b0;
      invalid_flag   <= 1'b0;
      trap_state_reg <= TRAP_IDLE;
      late_cnt_reg   <= 3'h0;
    end else begin
      fcc_reg        <= fcc_next;
      if (instr_valid) begin
        legacy_cc_reg <= fcc_reg[0];
      end
      invalid_flag   <= flag_next;
      trap_state_reg <= trap_state_next;
      late_cnt_reg   <= late_cnt_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      branch_redirect    <= 1'b0;
      branch_target      <= 32'h0;
      nullify_delay_slot <= 1'b0;
      cop_unusable_exc   <= 1'b0;
      reserved_instr_exc <= 1'b0;
      invalid_trap       <= 1'b0;
      invalid_trap_late  <= 1'b0;
    end else begin
      branch_redirect    <= br_ok && br_taken;
      branch_target      <= br_ok ? br_target : branch_target;
      nullify_delay_slot <= br_ok && !br_taken && nullify_flag;
      cop_unusable_exc   <= unusable;
      reserved_instr_exc <= reserved;
      invalid_trap       <= trap_now;
      invalid_trap_late  <= late_fire;
    end
  end

  assign fp_condition_bits = fcc_reg;

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  sequence s_late_cause;
    late_event && (trap_state_reg == TRAP_IDLE);
  endsequence
  sequence s_late_wait;
    !invalid_trap_late [*3];
  endsequence

  property p_target;
    @(posedge sys_clk) disable iff (!rst_n)
    branch_redirect |-> branch_target == $past(instr_pc) + 32'h4 +
      {{14{$past(instr_word[15])}}, $past(instr_word[15:0]), 2'b00};
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_taken;
    @(posedge sys_clk) disable iff (!rst_n)
    (br_ok && arch_extended) |=>
      branch_redirect == ($past(fcc_reg[br_select]) == $past(instr_word[16]));
  endproperty
  a_taken: assert property (p_taken) else $error("taken decision wrong");

  property p_nullify;
    @(posedge sys_clk) disable iff (!rst_n)
    nullify_delay_slot |-> !branch_redirect && $past(instr_word[17]) && $past(br_ok);
  endproperty
  a_nullify: assert property (p_nullify) else $error("bad nullify");

  property p_legacy_sel;
    @(posedge sys_clk) disable iff (!rst_n)
    (is_branch && fpu_enable && !arch_extended && (br_select != 3'h0)) |=>
      reserved_instr_exc && !branch_redirect && !nullify_delay_slot;
  endproperty
  a_legacy_sel: assert property (p_legacy_sel) else $error("legacy select accepted");

  property p_cc_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (cmp_ok && !trap_now) |=> fp_condition_bits[$past(cmp_select)] == $past(cmp_result);
  endproperty
  a_cc_write: assert property (p_cc_write) else $error("code not written");

  property p_precise_trap;
    @(posedge sys_clk) disable iff (!rst_n)
    (cmp_ok && precise_model && invalid_enable && pred_code[3] && rel_un) |=>
      invalid_trap && invalid_flag && fp_condition_bits == $past(fcc_reg);
  endproperty
  a_precise_trap: assert property (p_precise_trap) else $error("precise trap wrong");

  property p_imprecise;
    @(posedge sys_clk) disable iff (!rst_n)
    (cmp_ok && !precise_model && !invalid_flag && !invalid_flag_clear) |=>
      !invalid_flag && !invalid_trap;
  endproperty
  a_imprecise: assert property (p_imprecise) else $error("imprecise set flag");

  property p_late_trap;
    @(posedge sys_clk) disable iff (!rst_n)
    s_late_cause |=> s_late_wait ##1 invalid_trap_late;
  endproperty
  a_late_trap: assert property (p_late_trap) else $error("late trap timing");

  property p_unusable;
    @(posedge sys_clk) disable iff (!rst_n)
    unusable |=> cop_unusable_exc && !branch_redirect && fp_condition_bits == $past(fcc_reg);
  endproperty
  a_unusable: assert property (p_unusable) else $error("unusable not raised");

  property p_one_rel;
    @(posedge sys_clk) disable iff (!rst_n)
    cmp_ok |-> $onehot({rel_gt, rel_lt, rel_eq, rel_un});
  endproperty
  a_one_rel: assert property (p_one_rel) else $error("relations not exclusive");

endmodule // fcb_top
`default_nettype wire

// >>> core/fcb_pkg.sv
package fcb_pkg;

  // ==========================================================================
  // Instruction field positions.
  // ==========================================================================
  localparam int OPC_MSB    = 31;
  localparam int OPC_LSB    = 26;
  localparam int SUB_MSB    = 25;
  localparam int SUB_LSB    = 21;
  localparam int BCC_MSB    = 20;
  localparam int BCC_LSB    = 18;
  localparam int ND_BIT     = 17;
  localparam int TF_BIT     = 16;
  localparam int OFF_MSB    = 15;
  localparam int OFF_LSB    = 0;
  localparam int SRB_MSB    = 20;
  localparam int SRB_LSB    = 16;
  localparam int SRA_MSB    = 15;
  localparam int SRA_LSB    = 11;
  localparam int CCC_MSB    = 10;
  localparam int CCC_LSB    = 8;
  localparam int ZRO_MSB    = 7;
  localparam int ZRO_LSB    = 6;
  localparam int CLS_MSB    = 5;
  localparam int CLS_LSB    = 4;
  localparam int PRED_MSB   = 3;
  localparam int PRED_LSB   = 0;
  localparam int PRED_SIG   = 3;
  localparam int PRED_LT    = 2;
  localparam int PRED_EQ    = 1;
  localparam int PRED_UN    = 0;

  // ==========================================================================
  // Encodings and widths.
  // ==========================================================================
  localparam logic [5:0] FP_MAJOR_OPCODE = 6'h11;
  localparam logic [4:0] BC_SUB_OPCODE   = 5'h08;
  localparam logic [4:0] FMT_SINGLE      = 5'h10;
  localparam logic [4:0] FMT_DOUBLE      = 5'h11;
  localparam logic [1:0] CMP_CLASS       = 2'h3;
  localparam logic [1:0] ZERO_FIELD      = 2'h0;
  localparam logic [2:0] CC_ZERO         = 3'h0;
  localparam int         NUM_CC          = 8;
  localparam int         ADDR_W          = 32;
  localparam int         OFF_W           = 16;
  localparam int         OFF_SHIFT       = 2;
  localparam int         SEXT_W          = ADDR_W - OFF_W - OFF_SHIFT;
  localparam logic [31:0] SLOT_BYTES     = 32'h4;
  localparam logic [7:0] FCC_RESET       = 8'h00;

  // ==========================================================================
  // Operand layouts.
  // ==========================================================================
  localparam int DBL_SIGN   = 63;
  localparam int DBL_EXP_L  = 52;
  localparam int SGL_SIGN   = 31;
  localparam int SGL_EXP_L  = 23;
  localparam logic [10:0] DBL_EXP_ONES = 11'h7ff;
  localparam logic [7:0]  SGL_EXP_ONES = 8'hff;

  // ==========================================================================
  // Deferred trap timing.
  // ==========================================================================
  localparam logic [2:0] LATE_TRAP_CYCLES = 3'h2;

  typedef enum logic [0:0] {TRAP_IDLE, TRAP_WAIT} fcb_trap_state_t;

endpackage

// >>> core/fcb_compare.sv
`timescale 1ns/1ps
`default_nettype none
module fcb_compare (
  // Operands.
  input  wire logic [63:0] operand_a,
  input  wire logic [63:0] operand_b,
  input  wire logic        is_double,
  // Ordering relations, exactly one high.
  output logic             rel_gt,
  output logic             rel_lt,
  output logic             rel_eq,
  output logic             rel_un
);
  import fcb_pkg::*;

  logic        sign_a;
  logic        sign_b;
  logic [62:0] mag_a;
  logic [62:0] mag_b;
  logic        nan_a;
  logic        nan_b;
  logic        both_zero;
  logic        less_ord;

  // Single operands sit in the low word; magnitude is compared as an integer.
  assign sign_a = is_double ? operand_a[DBL_SIGN] : operand_a[SGL_SIGN];
  assign sign_b = is_double ? operand_b[DBL_SIGN] : operand_b[SGL_SIGN];
  assign mag_a  = is_double ? operand_a[62:0] : {32'h0, operand_a[30:0]};
  assign mag_b  = is_double ? operand_b[62:0] : {32'h0, operand_b[30:0]};
  assign nan_a  = is_double ?
                  (operand_a[62:DBL_EXP_L] == DBL_EXP_ONES) && (operand_a[51:0] != 52'h0) :
                  (operand_a[30:SGL_EXP_L] == SGL_EXP_ONES) && (operand_a[22:0] != 23'h0);
  assign nan_b  = is_double ?
                  (operand_b[62:DBL_EXP_L] == DBL_EXP_ONES) && (operand_b[51:0] != 52'h0) :
                  (operand_b[30:SGL_EXP_L] == SGL_EXP_ONES) && (operand_b[22:0] != 23'h0);
  assign both_zero = (mag_a == 63'h0) && (mag_b == 63'h0);
  assign less_ord  = (sign_a && !sign_b) ||
                     (!sign_a && !sign_b && (mag_a < mag_b)) ||
                     (sign_a && sign_b && (mag_a > mag_b));

  assign rel_un = nan_a || nan_b;
  assign rel_eq = !rel_un && (both_zero || ((mag_a == mag_b) && (sign_a == sign_b)));
  assign rel_lt = !rel_un && !rel_eq && less_ord;
  assign rel_gt = !rel_un && !rel_eq && !less_ord;

endmodule // fcb_compare
`default_nettype wire

// >>> bench/fcb_fpr_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcb_fpr_model (
  // Clock.
  input  wire logic        sys_clk,
  // Register load from the bench.
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [63:0] wr_data,
  // Instruction being issued.
  input  wire logic [31:0] instr_word,
  // Operand read ports.
  output logic      [63:0] operand_a,
  output logic      [63:0] operand_b
);
  import fcb_pkg::*;

  logic [63:0] fpr_mem [32];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      fpr_mem[wr_idx] <= wr_data;
    end
  end

  // Operands follow the source fields of whatever word is on the bus, as a register file would.
  assign operand_a = fpr_mem[instr_word[SRA_MSB:SRA_LSB]];
  assign operand_b = fpr_mem[instr_word[SRB_MSB:SRB_LSB]];
endmodule // fcb_fpr_model
`default_nettype wire

// >>> bench/tb_fcb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fcb_top;
  import fcb_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rst_n, arch_extended, fpu_enable, precise_model, invalid_enable;
  logic        invalid_flag_clear, instr_valid, wr_en;
  logic [31:0] instr_word, instr_pc;
  logic [63:0] operand_a, operand_b, wr_data;
  logic [4:0]  wr_idx;
  logic        branch_redirect, nullify_delay_slot, cop_unusable_exc, reserved_instr_exc;
  logic        invalid_trap, invalid_trap_late, invalid_flag;
  logic [31:0] branch_target;
  logic [7:0]  fp_condition_bits, exp_cc;
  int          err_count = 0;
  int          tests_run = 0;
  int          cycle_count = 0;

  fcb_top fcb_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .arch_extended(arch_extended),
    .fpu_enable(fpu_enable), .precise_model(precise_model), .invalid_enable(invalid_enable),
    .invalid_flag_clear(invalid_flag_clear), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .operand_a(operand_a),
    .operand_b(operand_b), .branch_redirect(branch_redirect), .branch_target(branch_target),
    .nullify_delay_slot(nullify_delay_slot), .cop_unusable_exc(cop_unusable_exc),
    .reserved_instr_exc(reserved_instr_exc), .invalid_trap(invalid_trap),
    .invalid_trap_late(invalid_trap_late), .invalid_flag(invalid_flag),
    .fp_condition_bits(fp_condition_bits));
  fcb_fpr_model fcb_fpr_model_inst (.sys_clk(sys_clk), .wr_en(wr_en), .wr_idx(wr_idx),
    .wr_data(wr_data), .instr_word(instr_word), .operand_a(operand_a),
    .operand_b(operand_b));

  always #4 sys_clk = ~sys_clk;

  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycle_count++;
    if (cycle_count == 3000) begin
      err_count++;
      tally_and_finish;
    end
  end

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic send(input logic [31:0] w, input logic [31:0] pc);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    instr_pc    <= pc;
  endtask

  // Ends the issue stream and lets the answering edge land before sampling.
  task automatic settle;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  function automatic logic [31:0] cmp_w(logic [4:0] fmt, logic [4:0] rb, logic [4:0] ra,
                                        logic [2:0] cc, logic [3:0] pred);
    return {FP_MAJOR_OPCODE, fmt, rb, ra, cc, ZERO_FIELD, CMP_CLASS, pred};
  endfunction

  function automatic logic [31:0] br_w(logic [2:0] cc, logic nd, logic tf, logic [15:0] off);
    return {FP_MAJOR_OPCODE, BC_SUB_OPCODE, cc, nd, tf, off};
  endfunction

  // Register 3 holds +0 and register 4 holds -0, so predicate 2 gives 1 and 0 gives 0.
  task automatic set_cc(input logic [2:0] cc, input logic v);
    send(cmp_w(FMT_DOUBLE, 5'h04, 5'h03, cc, v ? 4'h2 : 4'h0), 32'h0);
    settle;
    exp_cc[cc] = v;
    chk("set code", fp_condition_bits, exp_cc);
  endtask

  task automatic clear_flag;
    @(posedge sys_clk);
    invalid_flag_clear <= 1'b1;
    @(posedge sys_clk);
    invalid_flag_clear <= 1'b0;
    #1;
    chk("flag clear", invalid_flag, 1'b0);
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_compare;
    logic [4:0] ra [5] = '{5'h02, 5'h01, 5'h03, 5'h05, 5'h06};
    logic [4:0] rb [5] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h07};
    logic [3:0] rel [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h8};
    logic [2:0] cc;
    for (int k = 0; k < 5; k++) begin
      for (int p = 0; p < 16; p++) begin
        cc = p[2:0] ^ k[2:0];
        send(cmp_w(k == 4 ? FMT_SINGLE : FMT_DOUBLE, rb[k], ra[k], cc, p[3:0]), 32'h0);
        settle;
        exp_cc[cc] = |(p[2:0] & rel[k][2:0]);
        chk("compare code", fp_condition_bits, exp_cc);
        chk("imprecise flag", {invalid_flag, invalid_trap}, 2'b00);
      end
    end
    $display("test compare done");
  endtask

  task automatic t_branch;
    logic [15:0] offs [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
    logic [31:0] pc;
    logic [31:0] tgt;
    logic        taken;
    for (int c = 0; c < 8; c++) begin
      set_cc(c[2:0], c[0]);
    end
    for (int i = 0; i < 32; i++) begin
      pc = 32'h0000_1000 * (i + 1);
      send(br_w(i[2:0], i[3], i[4], offs[i % 4]), pc);
      settle;
      taken = (exp_cc[i[2:0]] == i[4]);
      chk("redirect", branch_redirect, taken);
      chk("nullify", nullify_delay_slot, i[3] & ~taken);
      tgt = pc + 32'h4 + {{14{offs[i % 4][15]}}, offs[i % 4], 2'b00};
      chk("target", branch_target, tgt);
    end
    $display("test branch done");
  endtask

  task automatic t_levels;
    set_cc(3'h2, 1'b0);
    send(cmp_w(FMT_DOUBLE, 5'h04, 5'h03, 3'h2, 4'h2), 32'h0);
    send(br_w(3'h2, 1'b0, 1'b1, 16'h0010), 32'h0000_2000);
    settle;
    exp_cc[2] = 1'b1;
    chk("back to back", branch_redirect, 1'b1);
    @(posedge sys_clk);
    arch_extended <= 1'b0;
    set_cc(3'h0, 1'b0);
    send(cmp_w(FMT_DOUBLE, 5'h04, 5'h03, 3'h0, 4'h2), 32'h0);
    send(br_w(3'h0, 1'b0, 1'b1, 16'h0010), 32'h0000_3000);
    settle;
    exp_cc[0] = 1'b1;
    chk("legacy stale code", branch_redirect, 1'b0);
    set_cc(3'h0, 1'b0);
    set_cc(3'h0, 1'b1);
    // A non-FP word fills the slot that legacy software keeps between compare and branch.
    send(32'h0, 32'h0);
    send(br_w(3'h0, 1'b0, 1'b1, 16'h0010), 32'h0000_3000);
    settle;
    chk("legacy spaced code", branch_redirect, 1'b1);
    send(br_w(3'h3, 1'b0, 1'b0, 16'h0010), 32'h0);
    settle;
    chk("legacy branch select", {reserved_instr_exc, branch_redirect}, 2'b10);
    send(cmp_w(FMT_DOUBLE, 5'h04, 5'h03, 3'h5, 4'h2), 32'h0);
    settle;
    chk("legacy cmp select", {reserved_instr_exc, fp_condition_bits}, {1'b1, exp_cc});
    @(posedge sys_clk);
    arch_extended <= 1'b1;
    $display("test levels done");
  endtask

  task automatic t_refuse;
    @(posedge sys_clk);
    fpu_enable <= 1'b0;
    send(cmp_w(FMT_DOUBLE, 5'h04, 5'h03, 3'h1, 4'h2), 32'h0);
    settle;
    chk("unit off compare", {cop_unusable_exc, fp_condition_bits}, {1'b1, exp_cc});
    send(br_w(3'h1, 1'b0, 1'b1, 16'h0010), 32'h0);
    settle;
    chk("unit off branch", {cop_unusable_exc, branch_redirect}, 2'b10);
    @(posedge sys_clk);
    fpu_enable <= 1'b1;
    send(cmp_w(5'h00, 5'h04, 5'h03, 3'h1, 4'h2), 32'h0);
    settle;
    chk("bad fmt", {reserved_instr_exc, fp_condition_bits}, {1'b1, exp_cc});
    send(cmp_w(FMT_DOUBLE, 5'h04, 5'h03, 3'h1, 4'h2) | 32'h40, 32'h0);
    settle;
    chk("zero bits", {reserved_instr_exc, fp_condition_bits}, {1'b1, exp_cc});
    $display("test refuse done");
  endtask

  task automatic t_invalid;
    int late_hits;
    @(posedge sys_clk);
    precise_model  <= 1'b1;
    invalid_enable <= 1'b1;
    set_cc(3'h3, 1'b0);
    send(cmp_w(FMT_DOUBLE, 5'h05, 5'h05, 3'h3, 4'h9), 32'h0);
    settle;
    chk("precise trap", {invalid_trap, invalid_flag}, 2'b11);
    chk("precise no write", fp_condition_bits, exp_cc);
    clear_flag;
    send(cmp_w(FMT_DOUBLE, 5'h05, 5'h05, 3'h3, 4'h1), 32'h0);
    settle;
    exp_cc[3] = 1'b1;
    chk("quiet predicate", {invalid_trap, invalid_flag}, 2'b00);
    chk("quiet code", fp_condition_bits, exp_cc);
    set_cc(3'h3, 1'b0);
    @(posedge sys_clk);
    invalid_enable <= 1'b0;
    send(cmp_w(FMT_DOUBLE, 5'h05, 5'h05, 3'h3, 4'h9), 32'h0);
    settle;
    exp_cc[3] = 1'b1;
    chk("precise disabled", {invalid_trap, invalid_flag}, 2'b01);
    chk("disabled code", fp_condition_bits, exp_cc);
    clear_flag;
    @(posedge sys_clk);
    precise_model  <= 1'b0;
    invalid_enable <= 1'b1;
    set_cc(3'h4, 1'b0);
    send(cmp_w(FMT_DOUBLE, 5'h05, 5'h05, 3'h4, 4'h9), 32'h0);
    settle;
    exp_cc[4] = 1'b1;
    chk("imprecise write", {invalid_trap, invalid_flag, invalid_trap_late}, 3'b000);
    chk("imprecise code", fp_condition_bits, exp_cc);
    late_hits = 0;
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      #1;
      late_hits += (invalid_trap_late === 1'b1);
    end
    chk("late trap count", late_hits, 1);
    $display("test invalid done");
  endtask

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    logic [63:0] fpr_init [8] = '{64'h0, 64'h3ff0000000000000, 64'h4000000000000000, 64'h0,
      64'h8000000000000000, 64'h7ff8000000000000, 64'h3f800000, 64'hc0000000};
    {rst_n, arch_extended, precise_model, invalid_enable, invalid_flag_clear} = '0;
    {instr_valid, instr_word, instr_pc, wr_en, wr_idx, wr_data} = '0;
    fpu_enable = 1'b1;
    exp_cc = FCC_RESET;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    arch_extended <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      wr_en   <= 1'b1;
      wr_idx  <= i[4:0];
      wr_data <= fpr_init[i];
    end
    @(posedge sys_clk);
    wr_en <= 1'b0;
    #1;
    chk("reset codes", {invalid_flag, branch_redirect, fp_condition_bits}, 10'h000);
    t_compare;
    t_branch;
    t_levels;
    t_refuse;
    t_invalid;
    tally_and_finish;
  end
endmodule // tb_fcb_top
`default_nettype wire
